// file: src/flbus_host.sv
// host controller driving the word-wide flash bus pins from simple user requests
`timescale 1ns/10ps
`default_nettype none
module flbus_host
    import flbus_pkg::*;
#(
    parameter int unsigned READ_CYC  = flbus_pkg::READ_ACCESS_CYC,
    parameter int unsigned PULSE_CYC = flbus_pkg::WRITE_PULSE_CYC
) (
    // clock and reset
    input  wire logic                        core_clk,
    input  wire logic                        reset_n,
    // user request
    input  wire logic                        req_valid,
    output logic                             req_ready,
    input  wire flbus_pkg::flbus_op_t        req_op,
    input  wire logic [flbus_pkg::ADDR_W-1:0] req_addr,
    input  wire logic [flbus_pkg::DATA_W-1:0] req_cmd,
    input  wire logic [flbus_pkg::DATA_W-1:0] req_data,
    input  wire logic                        boot_protect_n,
    // user answer
    output logic                             resp_valid,
    output logic [flbus_pkg::DATA_W-1:0]     resp_data,
    output logic                             write_allowed,
    output logic                             read_allowed,
    // flash pins
    output logic [flbus_pkg::ADDR_W-1:0]     flash_addr,
    output logic                             flash_ce_n,
    output logic                             flash_oe_n,
    output logic                             flash_we_n,
    output logic                             reset_powerdown_n,
    output logic                             flash_wp_n,
    output logic [flbus_pkg::DATA_W-1:0]     data_lines_out,
    output logic                             data_lines_oe_n,
    input  wire logic [flbus_pkg::DATA_W-1:0] data_lines_in
);
    localparam int unsigned TW = 8;
    localparam int unsigned WAKE_MAX =
        (RESET_TO_OUTPUT_CYC > RESET_TO_WRITE_CYC) ? RESET_TO_OUTPUT_CYC : RESET_TO_WRITE_CYC;
    localparam int unsigned WW = $clog2(WAKE_MAX + 1);

    // counts the 8-bit phase timer cannot hold are refused while elaborating
    if (READ_CYC < 1 || PULSE_CYC < 1 || READ_CYC >= (1 << TW) || PULSE_CYC >= (1 << TW)
        || RESET_LOW_CYC >= (1 << TW) || BUS_GAP_CYC >= (1 << TW)) begin
        $error("flbus_host: cycle counts out of timer range");
    end

    flbus_state_t       state;
    flbus_state_t       next_state;
    logic               timer_load;
    logic [TW-1:0]      timer_value;
    logic               timer_done;
    logic               second_pending;
    logic [DATA_W-1:0]  second_data;
    logic [WW-1:0]      wake_cnt;
    logic               take;

    flbus_timer #(
        .W         (TW),
        .RESET_VAL (RESET_LOW_CYC - 1)
    ) u_timer (
        .core_clk   (core_clk),
        .reset_n    (reset_n),
        .load       (timer_load),
        .load_value (timer_value),
        .done       (timer_done)
    );

    // cycles since the flash left reset, saturating
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            wake_cnt <= '0;
        end else if (state == FLBUS_RST_LOW) begin
            wake_cnt <= '0;
        end else if (wake_cnt != WW'(WAKE_MAX)) begin
            wake_cnt <= wake_cnt + WW'(1);
        end
    end

    assign read_allowed  = (state != FLBUS_RST_LOW) && (wake_cnt >= WW'(RESET_TO_OUTPUT_CYC));
    assign write_allowed = (state != FLBUS_RST_LOW) && (wake_cnt >= WW'(RESET_TO_WRITE_CYC));

    always_comb begin
        req_ready = 1'b0;
        if (state == FLBUS_IDLE) begin
            unique case (req_op)
                FLBUS_OP_READ:   req_ready = read_allowed;
                FLBUS_OP_WRITE1: req_ready = write_allowed;
                FLBUS_OP_WRITE2: req_ready = write_allowed;
                FLBUS_OP_RESET:  req_ready = 1'b1;
            endcase
        end
    end

    assign take = req_valid && req_ready;

    always_comb begin
        next_state  = state;
        timer_load  = 1'b0;
        timer_value = '0;
        unique case (state)
            FLBUS_IDLE: begin
                if (take) begin
                    unique case (req_op)
                        FLBUS_OP_READ: begin
                            next_state  = FLBUS_RD;
                            timer_load  = 1'b1;
                            timer_value = TW'(READ_CYC - 1);
                        end
                        FLBUS_OP_RESET: begin
                            next_state  = FLBUS_RST_LOW;
                            timer_load  = 1'b1;
                            timer_value = TW'(RESET_LOW_CYC - 1);
                        end
                        default: next_state = FLBUS_WR_SETUP;
                    endcase
                end
            end
            FLBUS_WR_SETUP: begin
                next_state  = FLBUS_WR_PULSE;
                timer_load  = 1'b1;
                timer_value = TW'(PULSE_CYC - 1);
            end
            FLBUS_WR_PULSE: begin
                if (timer_done) begin
                    next_state = FLBUS_WR_HOLD;
                end
            end
            FLBUS_WR_HOLD: begin
                next_state  = FLBUS_GAP;
                timer_load  = 1'b1;
                timer_value = TW'(BUS_GAP_CYC - 1);
            end
            FLBUS_RD: begin
                if (timer_done) begin
                    next_state  = FLBUS_GAP;
                    timer_load  = 1'b1;
                    timer_value = TW'(BUS_GAP_CYC - 1);
                end
            end
            FLBUS_GAP: begin
                if (timer_done) begin
                    next_state = second_pending ? FLBUS_WR_SETUP : FLBUS_IDLE;
                end
            end
            FLBUS_RST_LOW: begin
                if (timer_done) begin
                    next_state = FLBUS_IDLE;
                end
            end
            default: next_state = FLBUS_IDLE;
        endcase
    end

    // power-up starts with the flash held in reset
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            state <= FLBUS_RST_LOW;
        end else begin
            state <= next_state;
        end
    end

    // second cycle of a two-step sequence follows after the bus gap
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            second_pending <= 1'b0;
            second_data    <= '0;
        end else if (take) begin
            second_pending <= (req_op == FLBUS_OP_WRITE2);
            second_data    <= req_data;
        end else if (state == FLBUS_GAP && timer_done) begin
            second_pending <= 1'b0;
        end
    end

    // address stays put over the whole sequence, write data over each bus cycle
    // one user address for every cycle
    // setup code rides the first cycle
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            flash_addr     <= '0;
            data_lines_out <= '0;
        end else if (take) begin
            flash_addr     <= req_addr;
            data_lines_out <= (req_op == FLBUS_OP_WRITE2) ? req_cmd : req_data;
        end else if (state == FLBUS_GAP && timer_done && second_pending) begin
            data_lines_out <= second_data;
        end
    end

    // read and write strobes, write enable low only in the pulse
    // output enable only outside write states
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            flash_ce_n <= 1'b1;
            flash_oe_n <= 1'b1;
            flash_we_n <= 1'b1;
        end else begin
            flash_ce_n <= !(next_state == FLBUS_RD || next_state == FLBUS_WR_SETUP
                            || next_state == FLBUS_WR_PULSE || next_state == FLBUS_WR_HOLD);
            flash_oe_n <= (next_state != FLBUS_RD);
            // we rises first so its edge latches
            flash_we_n <= (next_state != FLBUS_WR_PULSE);
        end
    end

    // data lines driven only across a write, never while reading
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            data_lines_oe_n <= 1'b1;
        end else begin
            data_lines_oe_n <= !(next_state == FLBUS_WR_SETUP || next_state == FLBUS_WR_PULSE
                                 || next_state == FLBUS_WR_HOLD);
        end
    end

    // reset pulse, on system reset and on a reset request
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            reset_powerdown_n <= 1'b0;
            flash_wp_n        <= 1'b0;
        end else begin
            reset_powerdown_n <= (next_state != FLBUS_RST_LOW);
            flash_wp_n        <= boot_protect_n;
        end
    end

    // sample read data at the end of the access time
    // read words passed on uninterpreted
    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            resp_valid <= 1'b0;
            resp_data  <= '0;
        end else begin
            resp_valid <= (state == FLBUS_RD) && timer_done;
            if (state == FLBUS_RD && timer_done) begin
                resp_data <= data_lines_in;
            end
        end
    end
endmodule
`default_nettype wire

// file: shared/flbus_pkg.sv
// package: constants, opcodes and timing for the flash bus host controller
`default_nettype none
package flbus_pkg;

    // clock and timing figures, times in ns
    localparam int unsigned CLK_PERIOD_NS       = 100;
    localparam int unsigned RESET_LOW_NS        = 100;
    localparam int unsigned RESET_TO_OUTPUT_NS  = 600;
    localparam int unsigned RESET_TO_WRITE_NS   = 1000;
    localparam int unsigned WRITE_PULSE_NS      = 200;
    localparam int unsigned READ_ACCESS_NS      = 300;
    localparam int unsigned BUS_GAP_NS          = 100;

    // least time to whole cycles, never under one
    function automatic int unsigned flbus_cyc_min(input int unsigned ns);
        int unsigned c;
        c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int unsigned RESET_LOW_CYC       = flbus_cyc_min(RESET_LOW_NS);
    localparam int unsigned RESET_TO_OUTPUT_CYC = flbus_cyc_min(RESET_TO_OUTPUT_NS);
    localparam int unsigned RESET_TO_WRITE_CYC  = flbus_cyc_min(RESET_TO_WRITE_NS);
    localparam int unsigned WRITE_PULSE_CYC     = flbus_cyc_min(WRITE_PULSE_NS);
    localparam int unsigned READ_ACCESS_CYC     = flbus_cyc_min(READ_ACCESS_NS);
    localparam int unsigned BUS_GAP_CYC         = flbus_cyc_min(BUS_GAP_NS);

    // bus widths
    localparam int unsigned ADDR_W = 20;
    localparam int unsigned DATA_W = 16;

    // command bytes written on the low data lines
    localparam logic [7:0] CMD_READ_ARRAY     = 8'hFF;
    localparam logic [7:0] CMD_READ_ID        = 8'h90;
    localparam logic [7:0] CMD_READ_STATUS    = 8'h70;
    localparam logic [7:0] CMD_CLEAR_STATUS   = 8'h50;
    localparam logic [7:0] CMD_BLOCK_ERASE    = 8'h20;
    localparam logic [7:0] CMD_CHIP_ERASE     = 8'h30;
    localparam logic [7:0] CMD_WORD_WRITE     = 8'h40;
    localparam logic [7:0] CMD_WORD_WRITE_ALT = 8'h10;
    localparam logic [7:0] CMD_SUSPEND        = 8'hB0;
    localparam logic [7:0] CMD_CONFIRM        = 8'hD0;
    localparam logic [7:0] CMD_LOCK_SETUP     = 8'h60;
    localparam logic [7:0] CMD_SET_BLOCK_LOCK = 8'h01;
    localparam logic [7:0] CMD_SET_PERM_LOCK  = 8'hF1;

    // identifier-mode word addresses, and the status after reset
    localparam logic [19:0] ID_MANUFACTURER_ADDR = 20'h00000;
    localparam logic [19:0] ID_DEVICE_ADDR       = 20'h00001;
    localparam logic [19:0] ID_PERM_LOCK_ADDR    = 20'h00003;
    localparam logic [19:0] ID_BLOCK_LOCK_OFFSET = 20'h00002;
    localparam logic [7:0]  STATUS_AFTER_RESET   = 8'h80;

    typedef enum logic [1:0] {
        FLBUS_OP_READ   = 2'h0,
        FLBUS_OP_WRITE1 = 2'h1,
        FLBUS_OP_WRITE2 = 2'h2,
        FLBUS_OP_RESET  = 2'h3
    } flbus_op_t;

    typedef enum logic [2:0] {
        FLBUS_IDLE     = 3'h0,
        FLBUS_WR_SETUP = 3'h1,
        FLBUS_WR_PULSE = 3'h3,
        FLBUS_WR_HOLD  = 3'h2,
        FLBUS_GAP      = 3'h6,
        FLBUS_RD       = 3'h4,
        FLBUS_RST_LOW  = 3'h5
    } flbus_state_t;

endpackage
`default_nettype wire

// file: src/flbus_timer.sv
// down-counting wait timer shared by all timed bus phases
`timescale 1ns/10ps
`default_nettype none
module flbus_timer #(
    parameter int unsigned W         = 8,
    parameter int unsigned RESET_VAL = 0
) (
    // clock and reset
    input  wire logic         core_clk,
    input  wire logic         reset_n,
    // control
    input  wire logic         load,
    input  wire logic [W-1:0] load_value,
    output logic              done
);
    logic [W-1:0] count;

    // refused while elaborating, so a bad width never reaches a netlist
    if (W < 2 || RESET_VAL >= (1 << W)) begin
        $error("flbus_timer: width too small for reset value");
    end

    always_ff @(posedge core_clk or negedge reset_n) begin
        if (!reset_n) begin
            count <= W'(RESET_VAL);
        end else if (load) begin
            count <= load_value;
        end else if (count != '0) begin
            count <= count - W'(1);
        end
    end

    assign done = (count == '0);
endmodule
`default_nettype wire

// file: verif/flbus_flash_model.sv
// behavioural word-wide flash device facing the host controller
`timescale 1ns/10ps
`default_nettype none
module flbus_flash_model
    import flbus_pkg::*;
#(
    parameter logic [15:0] MFR_CODE  = 16'h0001, // arbitrary identity value
    parameter logic [15:0] DEV_CODE  = 16'h0002, // arbitrary identity value
    parameter logic        SUPPLY_OK = 1'b1
) (
    // flash pins
    input  wire logic [19:0] addr,
    input  wire logic        ce_n,
    input  wire logic        oe_n,
    input  wire logic        we_n,
    input  wire logic        reset_powerdown_n,
    input  wire logic        wp_n,
    input  wire logic [15:0] dq_in,
    output logic      [15:0] dq_out
);
    logic [15:0] mem [int];
    logic        lk [int];
    logic        perm   = 1'b0;
    logic [1:0]  mode   = 2'h0;
    logic [7:0]  pend   = 8'h00;
    logic [7:0]  status = 8'h80;
    logic [15:0] last   = 16'h0000;
    function automatic logic [19:0] blk(input logic [19:0] a);
        return (a >= 20'hF8000) ? (a & 20'hFF000) : (a & 20'hF8000);
    endfunction
    function automatic logic locked(input logic [19:0] b);
        return (lk.exists(b) && lk[b]) || (!wp_n && b >= 20'hFE000);
    endfunction
    function automatic logic [15:0] rd(input logic [19:0] a);
        if (mode == 2'h2) return {8'h00, status};
        if (mode == 2'h1) begin
            if (a == 20'h00000) return MFR_CODE;
            if (a == 20'h00001) return DEV_CODE;
            if (a == 20'h00003) return {15'h0, perm};
            return (a == blk(a) + 20'h2) ? {15'h0, locked(blk(a))} : 16'h0000;
        end
        return mem.exists(a) ? mem[a] : 16'hFFFF;
    endfunction
    // alterations finish at once, never left busy
    task automatic take(input logic [19:0] a, input logic [15:0] d);
        if (!reset_powerdown_n) return;
        if (pend != 8'h00) begin
            if (SUPPLY_OK && pend != CMD_LOCK_SETUP && !locked(blk(a)))
                mem[a] = d;
            if (SUPPLY_OK && pend == CMD_LOCK_SETUP && !perm) begin
                if (d[7:0] == CMD_SET_BLOCK_LOCK) lk[blk(a)] = 1'b1;
                if (d[7:0] == CMD_SET_PERM_LOCK) perm = 1'b1;
                if (d[7:0] == CMD_CONFIRM) lk.delete();
            end
            pend = 8'h00;
            mode = 2'h2;
        end else case (d[7:0])
            CMD_READ_ARRAY:   mode = 2'h0;
            CMD_READ_ID:      mode = 2'h1;
            CMD_READ_STATUS:  mode = 2'h2;
            CMD_CLEAR_STATUS: status = 8'h80;
            CMD_WORD_WRITE, CMD_WORD_WRITE_ALT, CMD_LOCK_SETUP: pend = d[7:0];
            default: ;
        endcase
    endtask
    always @(posedge we_n) if (!ce_n) take(addr, dq_in);
    always @(posedge ce_n) if (!we_n) take(addr, dq_in);
    always @(negedge reset_powerdown_n) begin
        mode = 2'h0;
        pend = 8'h00;
        status = 8'h80;
    end
    // released lines show the inverse, not a held value
    wire logic drive = !ce_n && !oe_n && we_n && reset_powerdown_n;
    always @(posedge oe_n) last = rd(addr);
    assign dq_out = drive ? rd(addr) : ~last;
endmodule
`default_nettype wire

// file: verif/flbus_host_checker.sv
// checker: pin-level assertions on the flash host ports
`timescale 1ns/10ps
`default_nettype none
module flbus_host_checker
    import flbus_pkg::*;
#(
    parameter int unsigned READ_CYC  = 3,
    parameter int unsigned PULSE_CYC = 2
) (
    input wire logic                      core_clk,
    input wire logic                      reset_n,
    input wire logic                      req_valid,
    input wire logic                      req_ready,
    input wire flbus_pkg::flbus_op_t      req_op,
    input wire logic                      resp_valid,
    input wire logic                      read_allowed,
    input wire logic                      write_allowed,
    input wire logic [flbus_pkg::ADDR_W-1:0] flash_addr,
    input wire logic                      flash_ce_n,
    input wire logic                      flash_oe_n,
    input wire logic                      flash_we_n,
    input wire logic                      reset_powerdown_n,
    input wire logic [flbus_pkg::DATA_W-1:0] data_lines_out,
    input wire logic                      data_lines_oe_n
);
    // the windows below are counted for the default phase lengths
    if (READ_CYC != 3 || PULSE_CYC != 2) begin
        $error("flbus_host_checker: windows assume default cycle counts");
    end
    default clocking @(posedge core_clk); endclocking
    default disable iff (!reset_n);
    wire logic take = req_valid && req_ready;
    wire logic take_rd = take && req_op == FLBUS_OP_READ;
    wire logic take_wr = take && (req_op == FLBUS_OP_WRITE1 || req_op == FLBUS_OP_WRITE2);
    oe_we_excl_a: assert property (flash_oe_n || flash_we_n)
        else $error("output and write enable low together");
    read_pins_a: assert property (take_rd |=> (!flash_ce_n && !flash_oe_n)[*3] ##1 flash_oe_n)
        else $error("read strobe window wrong");
    read_resp_a: assert property (take_rd |-> ##4 resp_valid ##1 !resp_valid)
        else $error("read answer late or long");
    read_quiet_a: assert property (!flash_oe_n |-> flash_we_n && reset_powerdown_n && data_lines_oe_n)
        else $error("read cycle not clean");
    write_pulse_a: assert property (take_wr |=> flash_we_n && !flash_ce_n && !data_lines_oe_n
        ##1 (!flash_we_n)[*2] ##1 flash_we_n && !flash_ce_n)
        else $error("write strobe shape wrong");
    latch_stable_a: assert property ($rose(flash_we_n) |-> !flash_ce_n && $stable(flash_addr)
        && $stable(data_lines_out))
        else $error("address or data moved at latch edge");
    rst_pins_a: assert property (!reset_powerdown_n |-> flash_ce_n && flash_oe_n && flash_we_n)
        else $error("strobes active in flash reset");
    rst_wake_a: assert property ($rose(reset_powerdown_n) |-> (!read_allowed && !write_allowed)[*5])
        else $error("access allowed inside wake interval");
endmodule
bind flbus_host flbus_host_checker #(.READ_CYC(READ_CYC), .PULSE_CYC(PULSE_CYC)) chk_u (
    .core_clk(core_clk), .reset_n(reset_n), .req_valid(req_valid), .req_ready(req_ready),
    .req_op(req_op), .resp_valid(resp_valid), .read_allowed(read_allowed),
    .write_allowed(write_allowed), .flash_addr(flash_addr), .flash_ce_n(flash_ce_n),
    .flash_oe_n(flash_oe_n), .flash_we_n(flash_we_n), .reset_powerdown_n(reset_powerdown_n),
    .data_lines_out(data_lines_out), .data_lines_oe_n(data_lines_oe_n));
`default_nettype wire

// file: verif/flbus_host_test.sv
// testbench: host controller driving a behavioural flash device
`timescale 1ns/10ps
`default_nettype none
module flbus_host_test;
    import flbus_pkg::*;
    localparam logic [15:0] MFR = 16'h00C3; // arbitrary identity value
    localparam logic [15:0] DEV = 16'h005A; // arbitrary identity value
    logic              core_clk = 1'b0;
    logic              reset_n = 1'b0;
    logic              req_valid = 1'b0;
    logic              boot_protect_n = 1'b1;
    flbus_op_t         req_op = FLBUS_OP_READ;
    logic [19:0]       req_addr = '0;
    logic [15:0]       req_cmd = '0;
    logic [15:0]       req_data = '0;
    logic              req_ready, resp_valid, write_allowed, read_allowed;
    logic              ce_n, oe_n, we_n, reset_powerdown_n, wp_n, dq_oe_n;
    logic [19:0]       flash_addr;
    logic [15:0]       resp_data, dq_out, dev_q, bus;
    int                failures = 0;
    int                checked = 0;
    assign bus = dq_oe_n ? dev_q : dq_out;
    flbus_host dut_u (.core_clk(core_clk), .reset_n(reset_n), .req_valid(req_valid),
        .req_ready(req_ready), .req_op(req_op), .req_addr(req_addr), .req_cmd(req_cmd),
        .req_data(req_data), .boot_protect_n(boot_protect_n), .resp_valid(resp_valid),
        .resp_data(resp_data), .write_allowed(write_allowed), .read_allowed(read_allowed),
        .flash_addr(flash_addr), .flash_ce_n(ce_n), .flash_oe_n(oe_n), .flash_we_n(we_n),
        .reset_powerdown_n(reset_powerdown_n), .flash_wp_n(wp_n), .data_lines_out(dq_out),
        .data_lines_oe_n(dq_oe_n), .data_lines_in(bus));
    flbus_flash_model #(.MFR_CODE(MFR), .DEV_CODE(DEV), .SUPPLY_OK(1'b1)) dev_u (
        .addr(flash_addr), .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n),
        .reset_powerdown_n(reset_powerdown_n),
        .wp_n(wp_n), .dq_in(bus), .dq_out(dev_q));
    initial forever #50 core_clk = ~core_clk;
    task automatic check(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %0t seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic summarize();
        if (failures == 0 && checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    // waits for ready under a bound, holding the request until the taking edge
    task automatic req(input flbus_op_t op, input logic [19:0] a, input logic [15:0] c, d);
        int n;
        n = 0;
        @(negedge core_clk);
        req_op = op;
        req_addr = a;
        req_cmd = c;
        req_data = d;
        req_valid = 1'b1;
        while (req_ready !== 1'b1 && n < 200) begin
            @(negedge core_clk);
            n++;
        end
        if (n == 200) check(16'h0, 16'h1);
        @(posedge core_clk);
        @(negedge core_clk);
        req_valid = 1'b0;
    endtask
    task automatic rdc(input logic [19:0] a, input logic [15:0] exp);
        int n;
        req(FLBUS_OP_READ, a, '0, '0);
        n = 0;
        while (resp_valid !== 1'b1 && n < 50) begin
            @(negedge core_clk);
            n++;
        end
        if (n == 50) check(16'h0, 16'h1);
        check(resp_data, exp);
    endtask
    task automatic wr2(input logic [19:0] a, input logic [15:0] c, d);
        req(FLBUS_OP_WRITE2, a, c, d);
    endtask
    task automatic wr1(input logic [19:0] a, input logic [15:0] d);
        req(FLBUS_OP_WRITE1, a, '0, d);
    endtask
    initial begin
        repeat (10) @(negedge core_clk);
        reset_n = 1'b1;
        rdc(20'h00100, 16'hFFFF);
        wr2(20'h00100, 16'h0040, 16'h1234);
        wr2(20'h00200, 16'h0010, 16'hA5C3);
        wr1(20'h00300, 16'h5555);
        wr1(20'h00000, 16'h00FF);
        rdc(20'h00100, 16'h1234);
        rdc(20'h00200, 16'hA5C3);
        rdc(20'h00300, 16'hFFFF);
        wr2(20'hFD000, 16'h0060, 16'h0001);
        wr2(20'hFD010, 16'h0040, 16'h7777);
        boot_protect_n = 1'b0;
        wr2(20'hFF010, 16'h0040, 16'h6666);
        // the write still runs after wr2 returns; lift protection once it is idle
        wr1(20'h00000, 16'h00FF);
        boot_protect_n = 1'b1;
        rdc(20'hFD010, 16'hFFFF);
        rdc(20'hFF010, 16'hFFFF);
        wr1(20'h00000, 16'h0090);
        rdc(20'h00000, MFR);
        rdc(20'h00001, DEV);
        rdc(20'h00003, 16'h0000);
        rdc(20'hFD002, 16'h0001);
        rdc(20'hFF002, 16'h0000);
        rdc(20'hFF001, 16'h0000);
        req(FLBUS_OP_RESET, 20'h0, '0, '0);
        rdc(20'h00100, 16'h1234);
        wr1(20'h00000, 16'h0070);
        rdc(20'h00000, 16'h0080);
        wr2(20'h00000, 16'h0060, 16'h00F1);
        wr2(20'hF0000, 16'h0060, 16'h0001);
        wr1(20'h00000, 16'h0090);
        rdc(20'hF0002, 16'h0000);
        rdc(20'h00003, 16'h0001);
        summarize();
    end
    initial begin
        #400000;
        failures++;
        summarize();
    end
endmodule
`default_nettype wire
